// ===== pkg/rcfg_pkg.sv
/*
 * Shared constants for the remote configuration command handler.
 * Assumes a 40 MHz clock common to both ends of the command link.
 */
package rcfg_pkg;
   // ==========================================================
   // Frame types and addresses
   localparam logic [7:0]  FT_REMOTE_REQ   = 8'h17;
   localparam logic [7:0]  FT_LOCAL_RESP   = 8'h88;
   localparam logic [7:0]  FT_REMOTE_RESP  = 8'h97;
   localparam logic [15:0] SHORT_USE_LONG  = 16'hFFFE;
   localparam logic [15:0] OWN_SHORT_RESET = 16'h0000;
   localparam logic [63:0] OWN_LONG_ADDR   = 64'h0000_0000_0000_0001;
   // ==========================================================
   // Commands
   localparam logic [15:0] CMD_APPLY       = 16'h0001;
   localparam logic [15:0] CMD_SAVE        = 16'h0002;
   localparam logic [15:0] CMD_DEFAULTS    = 16'h0003;
   localparam logic [15:0] CMD_RESTART     = 16'h0004;
   localparam logic [15:0] CMD_COMPAT      = 16'h0005;
   localparam logic [15:0] CMD_SERIAL_RATE = 16'h0006;
   localparam logic [15:0] CMD_DISCOVERY   = 16'h0007;
   // ==========================================================
   // Options, status, register fields
   localparam int          OPT_APPLY_BIT   = 1;
   localparam int          COMPAT_TX_BIT   = 0;
   localparam int          COMPAT_ND_BIT   = 1;
   localparam logic [1:0]  COMPAT_RESET    = 2'h0;
   localparam logic [7:0]  RATE_RESET      = 8'h03;
   localparam logic [7:0]  ST_OK           = 8'h00;
   localparam logic [7:0]  ST_ERROR        = 8'h01;
   localparam logic [7:0]  ST_BAD_CMD      = 8'h02;
   // ==========================================================
   // Payload limits in bytes
   localparam logic [7:0]  PAYLOAD_BEST    = 8'd116;
   localparam logic [7:0]  PAYLOAD_LEG_ENC = 8'd95;
   localparam logic [7:0]  PAYLOAD_LEG_CLR = 8'd100;
   localparam logic [7:0]  HDR_COST        = 8'd4;
   localparam logic [7:0]  LONG_SRC_COST   = 8'd6;
   localparam logic [7:0]  LONG_DST_COST   = 8'd6;
   localparam logic [7:0]  ENC_COST        = 8'd12;
   // ==========================================================
   // Timing
   localparam int          CLK_HZ          = 40_000_000;
   localparam int          RESTART_MS      = 100;
   localparam int          DISCOVERY_MS    = 2500;
   localparam int          RESTART_CYCLES  = CLK_HZ / 1000 * RESTART_MS;
   localparam int          DISC_CYCLES     = CLK_HZ / 1000 * DISCOVERY_MS;
endpackage : rcfg_pkg

// ===== pkg/rcfg_if.sv
/*
 * Link between the host controller and the radio command handler.
 * Assumes both ends share one clock; frames are one-cycle strobes.
 */
`timescale 1ns/1ps
interface rcfg_if;
   // Host to device request
   logic        req_valid;
   logic [7:0]  req_type;
   logic [7:0]  req_frame_id;
   logic [63:0] req_long;
   logic [15:0] req_short;
   logic [7:0]  req_options;
   logic [15:0] req_cmd;
   logic [7:0]  req_param;
   logic        req_has_param;
   // Over-the-air remote response arriving at the device
   logic        air_valid;
   logic [7:0]  air_frame_id;
   logic [7:0]  air_status;
   logic [7:0]  air_value;
   logic        air_disc_hit;
   // Device to host response frame
   logic        resp_valid;
   logic [7:0]  resp_type;
   logic [7:0]  resp_frame_id;
   logic [7:0]  resp_status;
   logic [7:0]  resp_value;
   logic        busy;
   modport device (input req_valid, req_type, req_frame_id, req_long, req_short,
                   req_options, req_cmd, req_param, req_has_param, air_valid,
                   air_frame_id, air_status, air_value, air_disc_hit,
                   output resp_valid, resp_type, resp_frame_id, resp_status,
                   resp_value, busy);
   modport host (output req_valid, req_type, req_frame_id, req_long, req_short,
                 req_options, req_cmd, req_param, req_has_param,
                 input resp_valid, resp_type, resp_frame_id, resp_status,
                 resp_value, busy);
endinterface : rcfg_if

// ===== design/rcfg_device.sv
/*
 * Device end: interprets configuration command frames, keeps pending,
 * active and nonvolatile parameter sets, runs restart and discovery timers.
 * Assumes the host honours the busy level and the request format.
 */
// Operation
// - Host uses FFFE short for long targeting.
// - Non-FFFE short routes by short only.
// - Host builds type 17 remote request.
// - Changes stay pending until applied.
// - Apply bit, apply command, or save+restart; save copies active, so restart drops pending.
// - Respond only for nonzero frame id; discovery results go out for id 0 too.
// - Air response becomes serial response frame.
// - Save copies active; reset loads nonvolatile.
// - Host waits for save acknowledgement.
// - Defaults command restores factory values.
// - Restart answers OK, resets 100 ms later.
// - Bit0 clear: computed payload, parallel messages.
// - Bit0 set: 95/100 payload, one message.
// - Bit1 clear: directed discovery ends on hit.
// - Bit1 set: discovery runs full timeout.
// - Compat field two bits, default zero.
// - Set bit0 for legacy broadcast streaming.
// - Bit1 set, no hits: send OK 88.
`timescale 1ns/1ps
module rcfg_device
   import rcfg_pkg::*;
#(
   parameter int RESTART_COUNT = RESTART_CYCLES,
   parameter int DISC_COUNT    = DISC_CYCLES
)(
   // Clock and reset
   input  wire logic  clock,
   input  wire logic  rst_n,
   // Command link
   rcfg_if.device     link,
   // Radio side settings
   input  wire logic  header_mode,
   input  wire logic  encryption_enable,
   input  wire logic  long_source,
   input  wire logic  long_dest,
   output logic [7:0] serial_rate,
   output logic [1:0] legacy_compat_config,
   output logic [7:0] max_payload,
   output logic       single_active_msg,
   output logic       restart_pulse
);
   typedef enum {IDLE, DISC, RESTART} state_t;
   state_t      state_reg;
   logic [31:0] timer_reg;
   logic        hit_reg;
   logic [7:0]  disc_id_reg;
   logic [7:0]  pend_rate_reg, nv_rate_reg;
   logic [1:0]  pend_compat_reg, nv_compat_reg;
   logic        addressed, is_req;
   // ==========================================================
   // Addressing
   // long-address routing for FFFE short, short-only routing otherwise
   assign addressed = (link.req_short == SHORT_USE_LONG) ? (link.req_long == OWN_LONG_ADDR)
                                                          : (link.req_short == OWN_SHORT_RESET);
   assign is_req = link.req_valid && link.req_type == FT_REMOTE_REQ && addressed
                   && state_reg == IDLE;
   // ==========================================================
   // Parameter sets
   always_ff @(posedge clock)
   begin
      if (!rst_n)
      begin
         nv_rate_reg   <= RATE_RESET;
         nv_compat_reg <= COMPAT_RESET;
      end
      else if (is_req && link.req_cmd == CMD_SAVE)
      begin
         nv_rate_reg   <= serial_rate;
         nv_compat_reg <= legacy_compat_config;
      end
   end
   always_ff @(posedge clock)
   begin
      if (!rst_n || restart_pulse)
      begin
         pend_rate_reg        <= nv_rate_reg;
         pend_compat_reg      <= nv_compat_reg;
         serial_rate          <= nv_rate_reg;
         legacy_compat_config <= nv_compat_reg;
      end
      else if (is_req)
      begin
         if (link.req_cmd == CMD_SERIAL_RATE && link.req_has_param)
            pend_rate_reg <= link.req_param;
         if (link.req_cmd == CMD_COMPAT && link.req_has_param)
            pend_compat_reg <= link.req_param[1:0];
         if (link.req_cmd == CMD_DEFAULTS)
         begin
            pend_rate_reg   <= RATE_RESET;
            pend_compat_reg <= COMPAT_RESET;
         end
         if (link.req_cmd == CMD_APPLY || link.req_options[OPT_APPLY_BIT])
         begin
            // An applied defaults request must land the defaults, not the old pending set.
            if (link.req_cmd == CMD_DEFAULTS)
            begin
               serial_rate          <= RATE_RESET;
               legacy_compat_config <= COMPAT_RESET;
            end
            else
            begin
               serial_rate          <= (link.req_cmd == CMD_SERIAL_RATE && link.req_has_param)
                                       ? link.req_param : pend_rate_reg;
               legacy_compat_config <= (link.req_cmd == CMD_COMPAT && link.req_has_param)
                                       ? link.req_param[1:0] : pend_compat_reg;
            end
         end
      end
   end
   // ==========================================================
   // Sequencing of restart and discovery
   always_ff @(posedge clock)
   begin
      if (!rst_n)
      begin
         state_reg     <= IDLE;
         timer_reg     <= '0;
         hit_reg       <= 1'b0;
         disc_id_reg   <= 8'h00;
         restart_pulse <= 1'b0;
      end
      else
      begin
         restart_pulse <= 1'b0;
         case (state_reg)
            IDLE:
            begin
               timer_reg <= '0;
               hit_reg   <= 1'b0;
               if (is_req && link.req_cmd == CMD_RESTART)
                  state_reg <= RESTART;
               else if (is_req && link.req_cmd == CMD_DISCOVERY)
               begin
                  state_reg   <= DISC;
                  disc_id_reg <= link.req_frame_id;
               end
            end
            RESTART:
            begin
               timer_reg <= timer_reg + 32'd1;
               if (timer_reg == 32'(RESTART_COUNT - 1))
               begin
                  restart_pulse <= 1'b1;
                  state_reg     <= IDLE;
               end
            end
            DISC:
            begin
               timer_reg <= timer_reg + 32'd1;
               if (link.air_valid && link.air_disc_hit)
                  hit_reg <= 1'b1;
               if (!legacy_compat_config[COMPAT_ND_BIT] && link.air_valid && link.air_disc_hit)
                  state_reg <= IDLE;
               else if (timer_reg == 32'(DISC_COUNT - 1))
                  state_reg <= IDLE;
            end
            default: state_reg <= IDLE;
         endcase
      end
   end
   // ==========================================================
   // Response frames
   always_ff @(posedge clock)
   begin
      if (!rst_n)
      begin
         link.resp_valid    <= 1'b0;
         link.resp_type     <= 8'h00;
         link.resp_frame_id <= 8'h00;
         link.resp_status   <= 8'h00;
         link.resp_value    <= 8'h00;
      end
      else
      begin
         link.resp_valid <= 1'b0;
         if (link.air_valid && !(state_reg == DISC && link.air_disc_hit))
         begin
            link.resp_valid    <= 1'b1;
            link.resp_type     <= FT_REMOTE_RESP;
            link.resp_frame_id <= link.air_frame_id;
            link.resp_status   <= link.air_status;
            link.resp_value    <= link.air_value;
         end
         else if (is_req && link.req_frame_id != 8'h00)
         begin
            link.resp_valid    <= 1'b1;
            link.resp_type     <= FT_REMOTE_RESP;
            link.resp_frame_id <= link.req_frame_id;
            link.resp_status   <= (link.req_cmd >= CMD_APPLY && link.req_cmd <= CMD_DISCOVERY)
                                  ? ST_OK : ST_BAD_CMD;
            link.resp_value    <= (link.req_cmd == CMD_COMPAT) ? {6'h00, pend_compat_reg}
                                                               : pend_rate_reg;
         end
         else if (state_reg == DISC && link.air_valid && link.air_disc_hit)
         begin
            link.resp_valid    <= 1'b1;
            link.resp_type     <= FT_LOCAL_RESP;
            link.resp_frame_id <= disc_id_reg;
            link.resp_status   <= ST_OK;
            link.resp_value    <= link.air_value;
         end
         else if (state_reg == DISC && timer_reg == 32'(DISC_COUNT - 1)
                  && !(legacy_compat_config[COMPAT_ND_BIT] && hit_reg))
         begin
            link.resp_valid    <= 1'b1;
            link.resp_type     <= FT_LOCAL_RESP;
            link.resp_frame_id <= disc_id_reg;
            link.resp_status   <= legacy_compat_config[COMPAT_ND_BIT] ? ST_OK : ST_ERROR;
            link.resp_value    <= 8'h00;
         end
      end
   end
   always_ff @(posedge clock)
   begin
      if (!rst_n)
         link.busy <= 1'b0;
      else
         link.busy <= (state_reg != IDLE) || is_req;
   end
   // ==========================================================
   // Transmit limits
   always_ff @(posedge clock)
   begin
      if (!rst_n)
      begin
         max_payload       <= PAYLOAD_BEST;
         single_active_msg <= 1'b0;
      end
      else if (legacy_compat_config[COMPAT_TX_BIT])
      begin
         max_payload       <= encryption_enable ? PAYLOAD_LEG_ENC : PAYLOAD_LEG_CLR;
         single_active_msg <= 1'b1;
      end
      else
      begin
         max_payload       <= PAYLOAD_BEST - (header_mode ? 8'd0 : HDR_COST)
                              - (long_source ? LONG_SRC_COST : 8'd0)
                              - (long_dest ? LONG_DST_COST : 8'd0)
                              - (encryption_enable ? ENC_COST : 8'd0);
         single_active_msg <= 1'b0;
      end
   end
endmodule : rcfg_device

// ===== design/rcfg_host.sv
/*
 * Host end: turns user command strobes into remote request frames.
 * Assumes the device shares the clock and raises busy while occupied.
 */
`timescale 1ns/1ps
module rcfg_host
   import rcfg_pkg::*;
(
   // Clock and reset
   input  wire logic        clock,
   input  wire logic        rst_n,
   // Command link
   rcfg_if.host             link,
   // User side
   input  wire logic        cmd_valid,
   input  wire logic [15:0] cmd_code,
   input  wire logic [63:0] cmd_long,
   input  wire logic [15:0] cmd_short,
   input  wire logic        cmd_use_long,
   input  wire logic        cmd_apply,
   input  wire logic [7:0]  cmd_frame_id,
   input  wire logic [7:0]  cmd_param,
   input  wire logic        cmd_has_param,
   output logic             cmd_ready,
   output logic             ans_valid,
   output logic [7:0]       ans_status,
   output logic [7:0]       ans_value
);
   logic save_wait_reg;
   // ==========================================================
   // Request issue
   always_ff @(posedge clock)
   begin
      if (!rst_n)
      begin
         link.req_valid     <= 1'b0;
         link.req_type      <= 8'h00;
         link.req_frame_id  <= 8'h00;
         link.req_long      <= '0;
         link.req_short     <= 16'h0000;
         link.req_options   <= 8'h00;
         link.req_cmd       <= 16'h0000;
         link.req_param     <= 8'h00;
         link.req_has_param <= 1'b0;
      end
      else
      begin
         link.req_valid <= cmd_valid && cmd_ready;
         if (cmd_valid && cmd_ready)
         begin
            link.req_type      <= FT_REMOTE_REQ;
            link.req_frame_id  <= cmd_frame_id;
            link.req_long      <= cmd_long;
            link.req_short     <= cmd_use_long ? SHORT_USE_LONG : cmd_short;
            link.req_options   <= cmd_apply ? 8'(1 << OPT_APPLY_BIT) : 8'h00;
            link.req_cmd       <= cmd_code;
            link.req_param     <= cmd_param;
            link.req_has_param <= cmd_has_param;
         end
      end
   end
   // ==========================================================
   // Flow control
   always_ff @(posedge clock)
   begin
      if (!rst_n)
         save_wait_reg <= 1'b0;
      else if (cmd_valid && cmd_ready && cmd_code == CMD_SAVE && cmd_frame_id != 8'h00)
         save_wait_reg <= 1'b1;
      else if (link.resp_valid)
         save_wait_reg <= 1'b0;
   end
   always_ff @(posedge clock)
   begin
      if (!rst_n)
         cmd_ready <= 1'b0;
      else
         cmd_ready <= !link.busy && !save_wait_reg && !(cmd_valid && cmd_ready)
                      && !link.req_valid;
   end
   always_ff @(posedge clock)
   begin
      if (!rst_n)
      begin
         ans_valid  <= 1'b0;
         ans_status <= 8'h00;
         ans_value  <= 8'h00;
      end
      else
      begin
         ans_valid  <= link.resp_valid;
         ans_status <= link.resp_status;
         ans_value  <= link.resp_value;
      end
   end
endmodule : rcfg_host

// ===== sim/rcfg_monitor.sv
/* Checker for the command link between host and device.
   Assumes it sees the link signals only, one clock, reset low. */
`timescale 1ns/1ps
module rcfg_monitor
   import rcfg_pkg::*;
(
   // Clock and reset
   input wire logic        clock,
   input wire logic        rst_n,
   // Requests and air traffic
   input wire logic        req_valid,
   input wire logic [7:0]  req_type,
   input wire logic [7:0]  req_frame_id,
   input wire logic [63:0] req_long,
   input wire logic [15:0] req_short,
   input wire logic        air_valid,
   input wire logic [7:0]  air_status,
   input wire logic [7:0]  air_value,
   input wire logic        air_disc_hit,
   // Responses
   input wire logic        resp_valid,
   input wire logic [7:0]  resp_type,
   input wire logic [7:0]  resp_frame_id,
   input wire logic [7:0]  resp_status,
   input wire logic [7:0]  resp_value,
   input wire logic        busy
);
   // ==========================================================
   // Sequences
   logic long_ok;
   logic short_ok;
   assign long_ok  = req_short == SHORT_USE_LONG && req_long == OWN_LONG_ADDR;
   assign short_ok = req_short != SHORT_USE_LONG && req_short == OWN_SHORT_RESET;
   default clocking @(posedge clock); endclocking
   default disable iff (!rst_n);
   // Air traffic wins the answer slot, so it is kept out.
   sequence take_s;
      req_valid && req_type == FT_REMOTE_REQ && !busy && !air_valid && (long_ok || short_ok);
   endsequence
   sequence fwd_s;
      air_valid && !air_disc_hit;
   endsequence
   // ==========================================================
   // Assertions
   answer_sent_a : assert property (take_s ##0 req_frame_id != 8'h00 |=>
      resp_valid && resp_frame_id == $past(req_frame_id)) else $error("no answer");
   answer_muted_a : assert property (take_s ##0 req_frame_id == 8'h00 |=>
      !resp_valid) else $error("answer for zero id");
   long_skip_a : assert property (req_valid && !busy && !air_valid &&
      req_short == SHORT_USE_LONG && !long_ok |=> !resp_valid) else $error("long miss taken");
   short_skip_a : assert property (req_valid && !busy && !air_valid &&
      req_short != SHORT_USE_LONG && !short_ok |=> !resp_valid) else $error("short miss taken");
   busy_take_a : assert property (take_s |=> busy) else $error("busy low");
   busy_bound_a : assert property ($rose(busy) |-> ##[1:80] !busy)
      else $error("busy stuck");
   req_type_a : assert property (req_valid |-> req_type == FT_REMOTE_REQ)
      else $error("bad request type");
   req_space_a : assert property (req_valid |=> !req_valid) else $error("requests too close");
   resp_hold_a : assert property (resp_valid |=> resp_valid || $stable(resp_status))
      else $error("status not held");
   air_fwd_a : assert property (fwd_s |=> resp_valid && resp_type == FT_REMOTE_RESP &&
      resp_status == $past(air_status) && resp_value == $past(air_value)) else $error("no fwd");
endmodule : rcfg_monitor

// ===== sim/remote_config_command_handler_test.sv
/* Bench joining host and device over the link.
   Assumes shortened restart and discovery counts set here. */
`timescale 1ns/1ps
module remote_config_command_handler_test;
   import rcfg_pkg::*;
   // ==========================================================
   // Setup
   localparam int RST_CNT = 20;
   localparam int DSC_CNT = 50;
   logic clock, rst_n, cmd_valid, cmd_use_long, cmd_apply, cmd_has_param, cmd_ready;
   logic [15:0] cmd_code, cmd_short;
   logic [63:0] cmd_long;
   logic [7:0]  cmd_frame_id, cmd_param, ans_status, ans_value, serial_rate, max_payload;
   logic        ans_valid, header_mode, encryption_enable, long_source, long_dest;
   logic [1:0]  legacy_compat_config;
   logic        single_active_msg, restart_pulse, got;
   int          bad_count, n_checks, at;
   rcfg_if link();
   rcfg_device #(.RESTART_COUNT(RST_CNT), .DISC_COUNT(DSC_CNT)) i_rcfg_device (.clock, .rst_n,
      .link, .header_mode, .encryption_enable, .long_source, .long_dest, .serial_rate,
      .legacy_compat_config, .max_payload, .single_active_msg, .restart_pulse);
   rcfg_host i_rcfg_host (.clock, .rst_n, .link, .cmd_valid, .cmd_code, .cmd_long, .cmd_short,
      .cmd_use_long, .cmd_apply, .cmd_frame_id, .cmd_param, .cmd_has_param, .cmd_ready,
      .ans_valid, .ans_status, .ans_value);
   rcfg_monitor i_rcfg_monitor (.clock(clock), .rst_n(rst_n), .req_valid(link.req_valid),
      .req_type(link.req_type), .req_frame_id(link.req_frame_id), .req_long(link.req_long),
      .req_short(link.req_short), .air_valid(link.air_valid), .air_status(link.air_status),
      .air_value(link.air_value), .air_disc_hit(link.air_disc_hit),
      .resp_valid(link.resp_valid), .resp_type(link.resp_type),
      .resp_frame_id(link.resp_frame_id), .resp_status(link.resp_status),
      .resp_value(link.resp_value), .busy(link.busy));
   initial
   begin
      clock = 1'b0;
      forever #12.5 clock = ~clock;
   end
   // ==========================================================
   // Helpers
   task check(input string what, input logic [63:0] seen, input logic [63:0] exp);
      n_checks++;
      if (seen !== exp)
      begin
         bad_count++;
         $display("wrong value %s expected %0h seen %0h", what, exp, seen);
      end
   endtask : check
   task wrap_up;
      $display("checks %0d mismatches %0d", n_checks, bad_count);
      if (bad_count == 0 && n_checks > 0)
         $display("NO MISMATCHES");
      else
         $display("MISMATCHES SEEN");
      $finish;
   endtask : wrap_up
   task tick(input int n);
      repeat (n) @(posedge clock);
      #1;
   endtask : tick
   task issue(input logic [15:0] code, input logic [7:0] prm, input logic [7:0] fid,
              input logic apl);
      for (int k = 0; cmd_ready !== 1'b1; k++)
      begin
         tick(1);
         if (k > 200)
         begin
            bad_count++;
            wrap_up();
         end
      end
      cmd_code = code;
      cmd_param = prm;
      cmd_frame_id = fid;
      cmd_apply = apl;
      cmd_valid = 1'b1;
      tick(1);
      cmd_valid = 1'b0;
   endtask : issue
   task await_ans(input int lim);
      got = 1'b0;
      for (int k = 0; k < lim && !got; k++)
      begin
         tick(1);
         got = ans_valid === 1'b1;
      end
   endtask : await_ans
   task ask(input logic [15:0] code, input logic [7:0] prm, input logic [7:0] fid,
            input logic apl, input logic want);
      issue(code, prm, fid, apl);
      await_ans(6);
      check("answer", got, want);
   endtask : ask
   task air_pulse(input logic hit, input logic [7:0] st, input logic [7:0] val);
      link.air_valid = 1'b1;
      link.air_disc_hit = hit;
      link.air_status = st;
      link.air_value = val;
      tick(1);
      link.air_valid = 1'b0;
   endtask : air_pulse
   // ==========================================================
   // Scenarios
   task settings_case;
      check("rate", serial_rate, RATE_RESET);
      check("compat", legacy_compat_config, COMPAT_RESET);
      check("payload", max_payload, PAYLOAD_BEST);
      ask(CMD_SERIAL_RATE, 8'h07, 8'h01, 1'b0, 1'b1);
      check("value", ans_value, RATE_RESET);
      check("old rate", serial_rate, RATE_RESET);
      ask(CMD_APPLY, 8'h00, 8'h02, 1'b0, 1'b1);
      check("applied", serial_rate, 8'h07);
      ask(CMD_SERIAL_RATE, 8'h09, 8'h00, 1'b1, 1'b0);
      check("bit apply", serial_rate, 8'h09);
      ask(16'h00FF, 8'h00, 8'h0A, 1'b0, 1'b1);
      check("bad cmd", ans_status, ST_BAD_CMD);
   endtask : settings_case
   task addr_case;
      cmd_use_long = 1'b1;
      cmd_long = 64'h5;
      ask(CMD_SERIAL_RATE, 8'h09, 8'h03, 1'b0, 1'b0);
      cmd_long = OWN_LONG_ADDR;
      ask(CMD_SERIAL_RATE, 8'h09, 8'h03, 1'b0, 1'b1);
      cmd_use_long = 1'b0;
      cmd_short = 16'h0003;
      ask(CMD_SERIAL_RATE, 8'h09, 8'h03, 1'b0, 1'b0);
      cmd_short = OWN_SHORT_RESET;
      cmd_long = 64'h5;
      ask(CMD_SERIAL_RATE, 8'h09, 8'h03, 1'b0, 1'b1);
   endtask : addr_case
   task compat_case;
      ask(CMD_COMPAT, 8'h01, 8'h04, 1'b1, 1'b1);
      tick(2);
      check("legacy clr", max_payload, PAYLOAD_LEG_CLR);
      check("single", single_active_msg, 1'b1);
      encryption_enable = 1'b1;
      header_mode = 1'b0;
      tick(2);
      check("legacy enc", max_payload, PAYLOAD_LEG_ENC);
      ask(CMD_COMPAT, 8'h00, 8'h05, 1'b1, 1'b1);
      long_source = 1'b1;
      long_dest = 1'b1;
      tick(2);
      check("worst", max_payload, PAYLOAD_BEST - HDR_COST - LONG_SRC_COST - LONG_DST_COST
         - ENC_COST);
      check("multi", single_active_msg, 1'b0);
   endtask : compat_case
   task nv_case;
      ask(CMD_SAVE, 8'h00, 8'h06, 1'b0, 1'b1);
      ask(CMD_DEFAULTS, 8'h00, 8'h07, 1'b1, 1'b1);
      check("default", serial_rate, RATE_RESET);
      issue(CMD_RESTART, 8'h00, 8'h08, 1'b0);
      at = -1;
      got = 1'b0;
      for (int k = 0; k < 40; k++)
      begin
         tick(1);
         got = got | (ans_valid === 1'b1);
         if (restart_pulse === 1'b1 && at < 0)
            at = k;
      end
      check("restart ok", got, 1'b1);
      check("restart status", ans_status, ST_OK);
      check("restart at", at, RST_CNT);
      check("nv rate", serial_rate, 8'h09);
   endtask : nv_case
   task disc_case;
      issue(CMD_DISCOVERY, 8'h00, 8'h00, 1'b0);
      tick(4);
      air_pulse(1'b1, ST_OK, 8'h5A);
      await_ans(4);
      check("hit value", ans_value, 8'h5A);
      check("hit type", link.resp_type, FT_LOCAL_RESP);
      tick(2);
      check("freed", link.busy, 1'b0);
      issue(CMD_DISCOVERY, 8'h00, 8'h00, 1'b0);
      await_ans(80);
      check("miss error", ans_status, ST_ERROR);
      ask(CMD_COMPAT, 8'h02, 8'h09, 1'b1, 1'b1);
      issue(CMD_DISCOVERY, 8'h00, 8'h00, 1'b0);
      tick(4);
      air_pulse(1'b1, ST_OK, 8'h33);
      tick(10);
      check("held", link.busy, 1'b1);
      await_ans(60);
      check("silent end", got, 1'b0);
      issue(CMD_DISCOVERY, 8'h00, 8'h00, 1'b0);
      await_ans(80);
      check("miss seen", got, 1'b1);
      check("miss ok", ans_status, ST_OK);
      check("miss type", link.resp_type, FT_LOCAL_RESP);
      air_pulse(1'b0, 8'h04, 8'h66);
      await_ans(4);
      check("fwd type", link.resp_type, FT_REMOTE_RESP);
      check("fwd status", ans_status, 8'h04);
   endtask : disc_case
   // ==========================================================
   // Main sequence
   initial
   begin
      bad_count = 0;
      n_checks = 0;
      rst_n = 1'b0;
      cmd_valid = 1'b0;
      {cmd_code, cmd_long, cmd_short, cmd_frame_id, cmd_param} = '0;
      {cmd_use_long, cmd_apply, encryption_enable, long_source, long_dest} = '0;
      cmd_has_param = 1'b1;
      header_mode = 1'b1;
      {link.air_valid, link.air_disc_hit, link.air_frame_id} = '0;
      {link.air_status, link.air_value} = '0;
      tick(4);
      rst_n = 1'b1;
      tick(2);
      settings_case();
      addr_case();
      compat_case();
      nv_case();
      disc_case();
      wrap_up();
   end
endmodule : remote_config_command_handler_test
